// file: hw/cpm_pkg.sv
package cpm_pkg;

   // ------------------------------------------------------------------
   // Bus geometry and register offsets
   // ------------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  OFF_PWR_TWO     = 8'h1a;
   localparam logic [7:0]  OFF_EXTRA_THREE = 8'h1b;
   localparam logic [7:0]  OFF_POP_CTRL    = 8'h1c;
   localparam logic [7:0]  OFF_CLK_DIV     = 8'h1e;
   localparam logic [7:0]  OFF_MIX_CTRL    = 8'h1f;
   localparam logic [7:0]  OFF_LEFT_GAIN   = 8'h20;
   localparam logic [7:0]  OFF_RIGHT_GAIN  = 8'h21;
   localparam logic [7:0]  OFF_KEY         = 8'h3f;

   // ------------------------------------------------------------------
   // Writable bit masks, reset values and the unlock key
   // ------------------------------------------------------------------
   localparam logic [15:0] PWR_TWO_MASK     = 16'h003b;
   localparam logic [15:0] EXTRA_THREE_MASK = 16'h0017;
   localparam logic [15:0] POP_CTRL_MASK    = 16'h001c;
   localparam logic [15:0] CLK_DIV_MASK     = 16'hff80;
   localparam logic [15:0] MIX_CTRL_MASK    = 16'h000f;
   localparam logic [15:0] LEFT_GAIN_MASK   = 16'h01ff;
   localparam logic [15:0] RIGHT_GAIN_MASK  = 16'h01f8;
   localparam logic [15:0] PWR_TWO_RST      = 16'h0000;
   localparam logic [15:0] EXTRA_THREE_RST  = 16'h0010;
   localparam logic [15:0] POP_CTRL_RST     = 16'h0000;
   localparam logic [15:0] CLK_DIV_RST      = 16'h0000;
   localparam logic [5:0]  AUTO_DIV_RST     = 6'h2f;
   localparam logic [15:0] MIX_CTRL_RST     = 16'h0000;
   localparam logic [15:0] LEFT_GAIN_RST    = 16'h0145;
   localparam logic [15:0] RIGHT_GAIN_RST   = 16'h0140;
   // Arbitrary unlock value.
   localparam logic [15:0] UNLOCK_KEY       = 16'h5a3c;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int RHP_ON_BIT    = 5;
   localparam int LSPK_ON_BIT   = 4;
   localparam int RSPK_ON_BIT   = 3;
   localparam int LHP_MUTE_BIT  = 1;
   localparam int RHP_MUTE_BIT  = 0;
   localparam int INT_MODE_BIT  = 4;
   localparam int RATE_LSB      = 0;
   localparam int STARTUP_BIT   = 4;
   localparam int MIDBUF_BIT    = 3;
   localparam int MIDRISE_BIT   = 2;
   localparam int DBDIV_LSB     = 13;
   localparam int GPDIV_LSB     = 10;
   localparam int TODIV_LSB     = 7;
   localparam int AUTO_LSB      = 1;
   localparam int LMIX_MUTE_BIT = 3;
   localparam int RMIX_MUTE_BIT = 2;
   localparam int LMIX_ON_BIT   = 1;
   localparam int RMIX_ON_BIT   = 0;
   localparam int LINE2_LSB     = 6;
   localparam int AMP_LSB       = 3;
   localparam int LINE3_LSB     = 0;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } cpm_bus_req_t;

   typedef struct packed {
      logic              right_headphone_amp_on;
      logic              left_speaker_amp_on;
      logic              right_speaker_amp_on;
      logic              left_headphone_silence;
      logic              right_headphone_silence;
      logic              rate_integer_family;
      logic [2:0]        rate_code;
      logic [16:0]       rate_hz;
      logic              startup_current_on;
      logic              midrail_buffer_on;
      logic              midrail_soft_rise;
      logic              left_boost_mixer_silence;
      logic              right_boost_mixer_silence;
      logic              left_boost_mixer_on;
      logic              right_boost_mixer_on;
      logic              left_amp_on;
      logic              right_amp_on;
      logic signed [5:0] left_line2_boost_db;
      logic signed [5:0] left_amp_boost_db;
      logic signed [5:0] left_line3_boost_db;
      logic signed [5:0] right_line2_boost_db;
      logic signed [5:0] right_amp_boost_db;
   } cpm_ctrl_t;

endpackage

// file: hw/cpm_regs.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module cpm_regs
   import cpm_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 rst_n,
   input  wire cpm_pkg::cpm_bus_req_t bus_req,
   output logic [15:0]               rd_data,
   input  wire logic                 left_input_path_on,
   input  wire logic                 right_input_path_on,
   input  wire logic                 auto_div_load,
   input  wire logic [5:0]           auto_div_value,
   output cpm_pkg::cpm_ctrl_t        ctrl,
   output logic                      low_clock_tick,
   output logic                      debounce_clock,
   output logic                      timeout_clock,
   output logic                      gpio_clock_out
);
   import cpm_pkg::*;

   // ------------------------------------------------------------------
   // Decoding helpers
   // ------------------------------------------------------------------
   function automatic logic signed [5:0] line_gain_db(input logic [2:0] code);
      logic signed [5:0] db;
      db = 6'sd0;
      case (code)
         3'h0, 3'h1: db = -6'sd12;
         3'h2:       db = -6'sd9;
         3'h3:       db = -6'sd6;
         3'h4:       db = -6'sd3;
         3'h5:       db = 6'sd0;
         3'h6:       db = 6'sd3;
         default:    db = 6'sd6;
      endcase
      return db;
   endfunction

   function automatic logic signed [5:0] amp_gain_db(input logic [2:0] code);
      logic signed [5:0] db;
      db = 6'sd0;
      case (code)
         3'h0:    db = 6'sd0;
         3'h1:    db = 6'sd6;
         3'h2:    db = 6'sd13;
         3'h3:    db = 6'sd18;
         3'h4:    db = 6'sd20;
         3'h5:    db = 6'sd24;
         3'h6:    db = 6'sd27;
         default: db = 6'sd29;
      endcase
      return db;
   endfunction

   function automatic logic [16:0] rate_to_hz(input logic int_mode, input logic [2:0] code);
      logic [16:0] hz;
      hz = 17'h0;
      if (int_mode)
      begin
         case (code)
            3'h0:    hz = 17'd48000;
            3'h1:    hz = 17'd32000;
            3'h2:    hz = 17'd24000;
            3'h3:    hz = 17'd16000;
            3'h4:    hz = 17'd12000;
            3'h5:    hz = 17'd8000;
            3'h6:    hz = 17'd96000;
            default: hz = 17'h0;
         endcase
      end
      else
      begin
         // The fractional family has no 32, 16 or 8 kHz members; those read as zero.
         case (code)
            3'h0:    hz = 17'd44100;
            3'h2:    hz = 17'd22050;
            3'h4:    hz = 17'd11025;
            3'h6:    hz = 17'd88200;
            default: hz = 17'h0;
         endcase
      end
      return hz;
   endfunction

   function automatic logic [16:0] debounce_last(input logic [2:0] code);
      logic [16:0] n;
      n = 17'h0;
      case (code)
         3'h0:    n = 17'd255;
         3'h1:    n = 17'd2047;
         3'h2:    n = 17'd4095;
         3'h3:    n = 17'd8191;
         3'h4:    n = 17'd16383;
         3'h5:    n = 17'd32767;
         3'h6:    n = 17'd64535;
         default: n = 17'd131071;
      endcase
      return n;
   endfunction

   function automatic logic [14:0] timeout_last(input logic [2:0] code);
      logic [15:0] n;
      n = 16'h100 << code;
      return n[14:0] - 15'h1;
   endfunction

   function automatic logic [3:0] gpio_last(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h0;
      case (code)
         3'h0:    n = 4'd0;
         3'h1:    n = 4'd1;
         3'h2:    n = 4'd2;
         3'h3:    n = 4'd3;
         3'h4:    n = 4'd5;
         3'h5:    n = 4'd7;
         3'h6:    n = 4'd11;
         default: n = 4'd15;
      endcase
      return n;
   endfunction

   function automatic logic hit(input cpm_bus_req_t req, input logic [7:0] off);
      return req.wr && (req.addr == off);
   endfunction

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic [15:0] pwr_two_r,     pwr_two_nxt;
   logic [15:0] extra_three_r, extra_three_nxt;
   logic [15:0] pop_ctrl_r,    pop_ctrl_nxt;
   logic [15:0] clk_div_r,     clk_div_nxt;
   logic [5:0]  auto_div_r,    auto_div_nxt;
   logic [15:0] mix_ctrl_r,    mix_ctrl_nxt;
   logic [15:0] left_gain_r,   left_gain_nxt;
   logic [15:0] right_gain_r,  right_gain_nxt;
   logic        unlocked_r,    unlocked_nxt;
   logic [15:0] rd_data_r,     rd_data_nxt;
   cpm_ctrl_t   ctrl_r,        ctrl_nxt;

   always_comb
   begin
      pwr_two_nxt     = hit(bus_req, OFF_PWR_TWO)     ? (bus_req.wdata & PWR_TWO_MASK)     : pwr_two_r;
      extra_three_nxt = hit(bus_req, OFF_EXTRA_THREE) ? (bus_req.wdata & EXTRA_THREE_MASK) : extra_three_r;
      pop_ctrl_nxt    = hit(bus_req, OFF_POP_CTRL)    ? (bus_req.wdata & POP_CTRL_MASK)    : pop_ctrl_r;
      clk_div_nxt     = hit(bus_req, OFF_CLK_DIV)     ? (bus_req.wdata & CLK_DIV_MASK)     : clk_div_r;
      mix_ctrl_nxt    = hit(bus_req, OFF_MIX_CTRL)    ? (bus_req.wdata & MIX_CTRL_MASK)    : mix_ctrl_r;
      left_gain_nxt   = hit(bus_req, OFF_LEFT_GAIN)   ? (bus_req.wdata & LEFT_GAIN_MASK)   : left_gain_r;
      right_gain_nxt  = hit(bus_req, OFF_RIGHT_GAIN)  ? (bus_req.wdata & RIGHT_GAIN_MASK)  : right_gain_r;

      // The key opens one write to the automatic field; any clock write closes it again.
      unlocked_nxt = unlocked_r;
      if (hit(bus_req, OFF_KEY))
         unlocked_nxt = (bus_req.wdata == UNLOCK_KEY);
      else if (hit(bus_req, OFF_CLK_DIV))
         unlocked_nxt = 1'b0;

      // Hardware loading beats a software write in the same cycle.
      auto_div_nxt = auto_div_r;
      if (auto_div_load)
         auto_div_nxt = auto_div_value;
      else if (hit(bus_req, OFF_CLK_DIV) && unlocked_r)
         auto_div_nxt = bus_req.wdata[AUTO_LSB +: 6];

      rd_data_nxt = 16'h0;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            OFF_PWR_TWO:     rd_data_nxt = pwr_two_r;
            OFF_EXTRA_THREE: rd_data_nxt = extra_three_r;
            OFF_POP_CTRL:    rd_data_nxt = pop_ctrl_r;
            OFF_CLK_DIV:     rd_data_nxt = clk_div_r | {9'h0, auto_div_r, 1'b0};
            OFF_MIX_CTRL:    rd_data_nxt = mix_ctrl_r;
            OFF_LEFT_GAIN:   rd_data_nxt = left_gain_r;
            OFF_RIGHT_GAIN:  rd_data_nxt = right_gain_r;
            OFF_KEY:         rd_data_nxt = {15'h0, unlocked_r};
            default:         rd_data_nxt = 16'h0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Control outputs follow the next register values so they move with the write.
   // ------------------------------------------------------------------
   always_comb
   begin
      ctrl_nxt.right_headphone_amp_on    = pwr_two_nxt[RHP_ON_BIT];
      ctrl_nxt.left_speaker_amp_on       = pwr_two_nxt[LSPK_ON_BIT];
      ctrl_nxt.right_speaker_amp_on      = pwr_two_nxt[RSPK_ON_BIT];
      ctrl_nxt.left_headphone_silence    = pwr_two_nxt[LHP_MUTE_BIT];
      ctrl_nxt.right_headphone_silence   = pwr_two_nxt[RHP_MUTE_BIT];
      ctrl_nxt.rate_integer_family       = extra_three_nxt[INT_MODE_BIT];
      ctrl_nxt.rate_code                 = extra_three_nxt[RATE_LSB +: 3];
      ctrl_nxt.rate_hz                   = rate_to_hz(extra_three_nxt[INT_MODE_BIT],
                                                      extra_three_nxt[RATE_LSB +: 3]);
      ctrl_nxt.startup_current_on        = pop_ctrl_nxt[STARTUP_BIT];
      ctrl_nxt.midrail_buffer_on         = pop_ctrl_nxt[MIDBUF_BIT];
      ctrl_nxt.midrail_soft_rise         = pop_ctrl_nxt[MIDRISE_BIT];
      ctrl_nxt.left_boost_mixer_silence  = mix_ctrl_nxt[LMIX_MUTE_BIT];
      ctrl_nxt.right_boost_mixer_silence = mix_ctrl_nxt[RMIX_MUTE_BIT];
      ctrl_nxt.left_boost_mixer_on       = mix_ctrl_nxt[LMIX_ON_BIT] | left_input_path_on;
      ctrl_nxt.right_boost_mixer_on      = mix_ctrl_nxt[RMIX_ON_BIT] | right_input_path_on;
      ctrl_nxt.left_amp_on               = left_input_path_on;
      ctrl_nxt.right_amp_on              = right_input_path_on;
      ctrl_nxt.left_line2_boost_db       = line_gain_db(left_gain_nxt[LINE2_LSB +: 3]);
      ctrl_nxt.left_amp_boost_db         = amp_gain_db(left_gain_nxt[AMP_LSB +: 3]);
      ctrl_nxt.left_line3_boost_db       = line_gain_db(left_gain_nxt[LINE3_LSB +: 3]);
      ctrl_nxt.right_line2_boost_db      = line_gain_db(right_gain_nxt[LINE2_LSB +: 3]);
      ctrl_nxt.right_amp_boost_db        = amp_gain_db(right_gain_nxt[AMP_LSB +: 3]);
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_two_r     <= PWR_TWO_RST;
         extra_three_r <= EXTRA_THREE_RST;
         pop_ctrl_r    <= POP_CTRL_RST;
         clk_div_r     <= CLK_DIV_RST;
         auto_div_r    <= AUTO_DIV_RST;
         mix_ctrl_r    <= MIX_CTRL_RST;
         left_gain_r   <= LEFT_GAIN_RST;
         right_gain_r  <= RIGHT_GAIN_RST;
         unlocked_r    <= 1'b0;
         rd_data_r     <= 16'h0;
         ctrl_r        <= '0;
      end
      else
      begin
         pwr_two_r     <= pwr_two_nxt;
         extra_three_r <= extra_three_nxt;
         pop_ctrl_r    <= pop_ctrl_nxt;
         clk_div_r     <= clk_div_nxt;
         auto_div_r    <= auto_div_nxt;
         mix_ctrl_r    <= mix_ctrl_nxt;
         left_gain_r   <= left_gain_nxt;
         right_gain_r  <= right_gain_nxt;
         unlocked_r    <= unlocked_nxt;
         rd_data_r     <= rd_data_nxt;
         ctrl_r        <= ctrl_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign ctrl    = ctrl_r;

   // ------------------------------------------------------------------
   // Clock dividers
   // ------------------------------------------------------------------
   // Dividers compare with >= so a divisor shrunk mid-count ends the period at once
   // instead of wrapping through the whole counter range.
   logic [5:0]  low_cnt_r, low_cnt_nxt;
   logic [16:0] db_cnt_r,  db_cnt_nxt;
   logic [14:0] to_cnt_r,  to_cnt_nxt;
   logic [3:0]  gp_cnt_r,  gp_cnt_nxt;
   logic        low_tick_r, low_tick_nxt;
   logic        db_tick_r,  db_tick_nxt;
   logic        to_tick_r,  to_tick_nxt;
   logic        gp_tick_r,  gp_tick_nxt;

   always_comb
   begin
      low_tick_nxt = (low_cnt_r >= auto_div_r);
      low_cnt_nxt  = low_tick_nxt ? 6'h0 : low_cnt_r + 6'h1;

      db_tick_nxt = 1'b0;
      db_cnt_nxt  = db_cnt_r;
      to_tick_nxt = 1'b0;
      to_cnt_nxt  = to_cnt_r;
      if (low_tick_nxt)
      begin
         db_tick_nxt = (db_cnt_r >= debounce_last(clk_div_r[DBDIV_LSB +: 3]));
         db_cnt_nxt  = db_tick_nxt ? 17'h0 : db_cnt_r + 17'h1;
         to_tick_nxt = (to_cnt_r >= timeout_last(clk_div_r[TODIV_LSB +: 3]));
         to_cnt_nxt  = to_tick_nxt ? 15'h0 : to_cnt_r + 15'h1;
      end

      gp_tick_nxt = (gp_cnt_r >= gpio_last(clk_div_r[GPDIV_LSB +: 3]));
      gp_cnt_nxt  = gp_tick_nxt ? 4'h0 : gp_cnt_r + 4'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         low_cnt_r  <= 6'h0;
         db_cnt_r   <= 17'h0;
         to_cnt_r   <= 15'h0;
         gp_cnt_r   <= 4'h0;
         low_tick_r <= 1'b0;
         db_tick_r  <= 1'b0;
         to_tick_r  <= 1'b0;
         gp_tick_r  <= 1'b0;
      end
      else
      begin
         low_cnt_r  <= low_cnt_nxt;
         db_cnt_r   <= db_cnt_nxt;
         to_cnt_r   <= to_cnt_nxt;
         gp_cnt_r   <= gp_cnt_nxt;
         low_tick_r <= low_tick_nxt;
         db_tick_r  <= db_tick_nxt;
         to_tick_r  <= to_tick_nxt;
         gp_tick_r  <= gp_tick_nxt;
      end
   end

   assign low_clock_tick = low_tick_r;
   assign debounce_clock = db_tick_r;
   assign timeout_clock  = to_tick_r;
   assign gpio_clock_out = gp_tick_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   amp_enable_write_a: assert property (hit(bus_req, OFF_PWR_TWO) |=>
      ctrl.right_headphone_amp_on == $past(bus_req.wdata[5]) &&
      ctrl.left_speaker_amp_on == $past(bus_req.wdata[4]) &&
      ctrl.right_speaker_amp_on == $past(bus_req.wdata[3]))
      else $error("amp enables do not follow power register write");

   hp_mute_write_a: assert property (hit(bus_req, OFF_PWR_TWO) ##1 !hit(bus_req, OFF_PWR_TWO) |=>
      ctrl.left_headphone_silence == $past(bus_req.wdata[1], 2) &&
      ctrl.right_headphone_silence == $past(bus_req.wdata[0], 2))
      else $error("headphone mutes lost after write");

   rate_decode_a: assert property (hit(bus_req, OFF_EXTRA_THREE) &&
      bus_req.wdata[4] && bus_req.wdata[2:0] == 3'h6 |=> ctrl.rate_hz == 17'd96000)
      else $error("integer family code 110 is not 96 kHz");

   rate_family_a: assert property (hit(bus_req, OFF_EXTRA_THREE) &&
      !bus_req.wdata[4] && bus_req.wdata[2:0] == 3'h0 |=> ctrl.rate_hz == 17'd44100)
      else $error("fractional family code 000 is not 44.1 kHz");

   pop_bias_a: assert property (hit(bus_req, OFF_POP_CTRL) |=>
      ctrl.startup_current_on == $past(bus_req.wdata[4]) &&
      ctrl.midrail_buffer_on == $past(bus_req.wdata[3]) &&
      ctrl.midrail_soft_rise == $past(bus_req.wdata[2]))
      else $error("pop control outputs do not follow write");

   locked_field_a: assert property (hit(bus_req, OFF_CLK_DIV) && !unlocked_r &&
      !auto_div_load |=> $stable(auto_div_r))
      else $error("automatic divider changed without key");

   mixer_enable_a: assert property (hit(bus_req, OFF_MIX_CTRL) &&
      bus_req.wdata[1] |=> ctrl.left_boost_mixer_on)
      else $error("left mixer not enabled by its bit");

   reserved_read_a: assert property (bus_req.rd && bus_req.addr == OFF_POP_CTRL |=>
      rd_data[15:5] == 11'h0 && rd_data[1:0] == 2'h0)
      else $error("reserved pop control bits read nonzero");

   gain_readback_a: assert property (hit(bus_req, OFF_LEFT_GAIN) ##1
      (bus_req.rd && bus_req.addr == OFF_LEFT_GAIN) |=>
      rd_data == ($past(bus_req.wdata, 2) & LEFT_GAIN_MASK))
      else $error("left gain read back differs from write");

   gpio_period_a: assert property (clk_div_r[12:10] == 3'h7 && $stable(clk_div_r) &&
      gpio_clock_out && gp_cnt_r == 4'h0 |-> ##8 (!gpio_clock_out || clk_div_r[12:10] != 3'h7)
      ##8 (gpio_clock_out || clk_div_r[12:10] != 3'h7))
      else $error("gpio divide by 16 period wrong");
endmodule

// file: dv/test_codec_power_clock_mixer_regs.sv
`timescale 1ns/1ps
module test_codec_power_clock_mixer_regs;
   import cpm_pkg::*;
   logic         sys_clk = 1'b0;
   logic         rst_n   = 1'b0;
   logic         lin_on  = 1'b0;
   logic         rin_on  = 1'b0;
   logic         ad_ld   = 1'b0;
   logic [5:0]   ad_val  = 6'h00;
   cpm_bus_req_t req     = '0;
   logic [15:0]  rd_data;
   cpm_ctrl_t    ctrl;
   logic         low_tick, db_clk, to_clk, gp_clk;
   logic         pend    = 1'b0;
   logic [15:0]  expq[$];
   logic [15:0]  rnd     = 16'h0018;
   logic [16:0]  n;
   int           n_fail  = 0;
   int           num_checks = 0;
   int           cyc     = 0;
   logic [7:0]   offs[7] = '{OFF_PWR_TWO, OFF_EXTRA_THREE, OFF_POP_CTRL, OFF_CLK_DIV, OFF_MIX_CTRL,
                            OFF_LEFT_GAIN, OFF_RIGHT_GAIN};
   logic [15:0]  msks[7] = '{PWR_TWO_MASK, EXTRA_THREE_MASK, POP_CTRL_MASK, CLK_DIV_MASK, MIX_CTRL_MASK,
                            LEFT_GAIN_MASK, RIGHT_GAIN_MASK};
   logic [15:0]  rsts[7] = '{16'h0000, 16'h0010, 16'h0000, 16'h005e, 16'h0000, 16'h0145, 16'h0140};
   logic [16:0]  hz[16]  = '{17'd44100, 17'd0, 17'd22050, 17'd0, 17'd11025, 17'd0, 17'd88200, 17'd0,
                            17'd48000, 17'd32000, 17'd24000, 17'd16000, 17'd12000, 17'd8000, 17'd96000, 17'd0};
   logic [5:0]   lg[8]   = '{6'h34, 6'h34, 6'h37, 6'h3a, 6'h3d, 6'h00, 6'h03, 6'h06};
   logic [5:0]   ag[8]   = '{6'h00, 6'h06, 6'h0d, 6'h12, 6'h14, 6'h18, 6'h1b, 6'h1d};
   logic [16:0]  gd[8]   = '{17'd1, 17'd2, 17'd3, 17'd4, 17'd6, 17'd8, 17'd12, 17'd16};

   cpm_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req), .rd_data(rd_data),
      .left_input_path_on(lin_on), .right_input_path_on(rin_on), .auto_div_load(ad_ld),
      .auto_div_value(ad_val), .ctrl(ctrl), .low_clock_tick(low_tick), .debounce_clock(db_clk),
      .timeout_clock(to_clk), .gpio_clock_out(gp_clk));

   always #4 sys_clk = ~sys_clk;

   // ------------------------------------------------------------------
   // Bus tasks, checking and closing
   // ------------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{a, d, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      expq.push_back(e);
   endtask
   // Releases the bus and waits until registered outputs have settled.
   task automatic settle;
      @(posedge sys_clk);
      req <= '0;
      repeat (2) @(negedge sys_clk);
   endtask
   task automatic load(input logic [5:0] v);
      @(posedge sys_clk);
      ad_ld  <= 1'b1;
      ad_val <= v;
      @(posedge sys_clk);
      ad_ld  <= 1'b0;
   endtask
   // Tick outputs by selector: 0 gpio, 1 low clock, 2 debounce, 3 timeout.
   function automatic logic pick(input logic [1:0] s);
      return s[1] ? (s[0] ? to_clk : db_clk) : (s[0] ? low_tick : gp_clk);
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Distance in cycles between two high samples of a tick output.
   task automatic gap(input logic [1:0] sel, output logic [16:0] c);
      int k;
      k = 0;
      c = '0;
      @(negedge sys_clk);
      while (pick(sel) !== 1'b1 && k < 3000)
      begin
         @(negedge sys_clk);
         k++;
      end
      do
      begin
         @(negedge sys_clk);
         c++;
      end while (pick(sel) !== 1'b1 && c < 17'd3000);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      pend <= req.rd;
      if (pend)
         chk("rd_data", expq.pop_front(), rd_data);
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 7; i++)
         rd(offs[i], rsts[i]);
      wr(8'h30, 16'hffff);
      rd(8'h30, 16'h0000);
      for (int k = 0; k < 21; k++)
      begin
         rnd = lfsr(rnd);
         wr(offs[k % 7], rnd);
         rd(offs[k % 7], (rnd & msks[k % 7]) | (rsts[k % 7] & ~msks[k % 7]));
      end
      for (int v = 0; v < 2; v++)
      begin
         rnd = v ? 16'h0017 : 16'h0028;
         wr(OFF_PWR_TWO, rnd);
         wr(OFF_POP_CTRL, rnd);
         settle();
         chk("pwr_two", {rnd[5:3], rnd[1:0]}, {ctrl.right_headphone_amp_on, ctrl.left_speaker_amp_on,
            ctrl.right_speaker_amp_on, ctrl.left_headphone_silence, ctrl.right_headphone_silence});
         chk("pop", rnd[4:2], {ctrl.startup_current_on, ctrl.midrail_buffer_on, ctrl.midrail_soft_rise});
      end
      for (int i = 0; i < 16; i++)
      begin
         wr(OFF_EXTRA_THREE, {11'h000, i[3], 1'b0, i[2:0]});
         settle();
         chk("rate", {hz[i], i[3], i[2:0]}, {ctrl.rate_hz, ctrl.rate_integer_family, ctrl.rate_code});
      end
      for (int c = 0; c < 8; c++)
      begin
         wr(OFF_LEFT_GAIN, {7'h00, c[2:0], c[2:0], c[2:0]});
         wr(OFF_RIGHT_GAIN, {7'h00, c[2:0], c[2:0], 3'h0});
         settle();
         chk("left_gain", {lg[c], ag[c], lg[c]}, {ctrl.left_line2_boost_db, ctrl.left_amp_boost_db,
            ctrl.left_line3_boost_db});
         chk("right_gain", {lg[c], ag[c]}, {ctrl.right_line2_boost_db, ctrl.right_amp_boost_db});
      end
      for (int i = 0; i < 32; i++)
      begin
         wr(OFF_MIX_CTRL, {12'h000, i[3:0]});
         lin_on <= i[4];
         rin_on <= i[4] ^ i[3];
         settle();
         chk("mixer", {i[3:2], i[1] | i[4], i[0] | (i[4] ^ i[3]), i[4], i[4] ^ i[3]}, {ctrl.left_boost_mixer_silence,
            ctrl.right_boost_mixer_silence, ctrl.left_boost_mixer_on, ctrl.right_boost_mixer_on,
            ctrl.left_amp_on, ctrl.right_amp_on});
      end
      wr(OFF_KEY, UNLOCK_KEY);
      wr(OFF_KEY, 16'h5a3d);
      rd(OFF_KEY, 16'h0000);
      wr(OFF_KEY, UNLOCK_KEY);
      rd(OFF_KEY, 16'h0001);
      wr(OFF_CLK_DIV, 16'h0006);
      rd(OFF_CLK_DIV, 16'h0006);
      wr(OFF_CLK_DIV, 16'h007e);
      rd(OFF_CLK_DIV, 16'h0006);
      settle();
      gap(1'b1, n);
      gap(1'b1, n);
      chk("low_tick_gap", 17'd4, n);
      for (int c = 0; c < 8; c++)
      begin
         wr(OFF_CLK_DIV, {3'h0, c[2:0], 10'h000});
         settle();
         gap(1'b0, n);
         gap(1'b0, n);
         chk("gpio_gap", gd[c], n);
      end
      load(6'h07);
      rd(OFF_CLK_DIV, 16'h1c0e);
      settle();
      gap(1'b1, n);
      gap(1'b1, n);
      chk("low_tick_gap", 17'd8, n);
      // A divide-by-one low clock keeps the debounce and timeout periods short enough to measure.
      load(6'h00);
      wr(OFF_CLK_DIV, 16'h2080);
      settle();
      gap(2'd1, n);
      chk("low_tick_gap", 17'd1, n);
      gap(2'd3, n);
      gap(2'd3, n);
      chk("timeout_gap", 17'd512, n);
      gap(2'd2, n);
      gap(2'd2, n);
      chk("debounce_gap", 17'd2048, n);
      end_sim();
   end
endmodule
